// ---- eeprom_cfg.svh ----
// Constants of the serial EEPROM command logic: opcodes, status fields, timing.
// Included by the package, the write timer and the EEPROM module; definitions only.
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

`define OPC_ARRAY_READ     3'h3
`define OPC_ARRAY_WRITE    3'h2
`define OPC_LATCH_CLEAR    3'h4
`define OPC_LATCH_SET      3'h6
`define OPC_STATUS_READ    3'h5
`define OPC_STATUS_WRITE   3'h1
`define STAT_BUSY_BIT      0
`define STAT_WEL_BIT       1
`define STAT_BP_LO_BIT     2
`define STAT_BP_HI_BIT     3
`define BP_RESET           2'h1
`define PAGE_BITS          4
`define WRITE_TIME_NS      5000000
`define CLK_PERIOD_NS      40
`define WRITE_CYCLES       (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- eeprom_pkg.sv ----
// Types shared by the serial EEPROM command logic.
// Assumes eeprom_cfg.svh is on the include path.
`include "eeprom_cfg.svh"

package eeprom_pkg;
	typedef enum logic [2:0] {
		ST_OPCODE  = 3'b000,
		ST_ADDR    = 3'b001,
		ST_DATA    = 3'b011,
		ST_STATUS  = 3'b010,
		ST_IGNORE  = 3'b110
	} link_state_t;
endpackage

// ---- pin_sync.sv ----
// Three-flop synchroniser for link-side levels crossing into ref_clk.
// Output changes once second and third stages agree.
`timescale 1ns/1ns

module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] reset_val,
	output      logic [W-1:0] sync_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge ref_clk) begin
		s1_r <= async_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				// Idle level at reset, so no false edge follows reset
				if (sys_rst)
					sync_out[i] <= reset_val[i];
				else if (s2_r[i] == s3_r[i])
					sync_out[i] <= s3_r[i];
			end
		end
	endgenerate
endmodule

// ---- write_timer.sv ----
// Self-timed write cycle counter in the ref_clk domain.
// Start is a one-cycle pulse; busy stays high for the programmed cycle count.
`timescale 1ns/1ns
`include "eeprom_cfg.svh"

module write_timer #(
	parameter int CYCLES = `WRITE_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic start,
	output      logic busy,
	output      logic done
);
	logic [23:0] cnt_r;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_r <= 24'h00_0000;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy  <= 1'b1;
				cnt_r <= 24'(CYCLES - 1);
			end else if (busy) begin
				if (cnt_r == 24'h00_0000) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else
					cnt_r <= cnt_r - 24'h00_0001;
			end
		end
	end
endmodule

// ---- spi_eeprom.sv ----
// Command logic of a 256-byte SPI serial EEPROM, with the serial engine on sck.
// Assumes the host keeps SPI mode 0 timing; write engine runs on ref_clk.
//
// What this block does
// - Instructions shift into an 8-bit register on rising serial clock edges.
// - All bytes move most significant bit first, both directions.
// - First instruction bit is taken on first rising edge after select falls.
// - Pause freezes clock and data; transfer resumes where it stopped.
// - Read opcode, then address; the stored byte shifts out.
// - Read address increments after each byte and wraps FFh to 00h.
// - Raising chip select ends a read.
// - Latch set only when select rises after all eight opcode bits.
// - Write carries up to 16 bytes within one page.
// - Write address wraps its low four bits within the page.
// - Write cycle starts only if select rises right after a whole byte.
// - No array data is returned while a write cycle runs.
// - Status read is accepted at any time, even while busy.
// - Latch cleared at reset, cycle end, clear/status/array write, protect low.
// - Array or status write completes only with the latch set.
// - Opcodes 0000x011 read and 0000x010 write, bit 3 ignored.
// - 0000x100 clear, 0000x110 set, 0000x101 status read, 0000x001 status write.
// - Status bit 0 is read-only busy.
// - Status bit 1 reads the latch; clear always works, set is ignored while protect is low.
// - Status bits 3:2 are block protect, loaded with 01 at reset and otherwise changed only by status write.
// - Protect codes: 00 none, 01 C0h-FFh, 10 80h-FFh, 11 all.
// - Array accesses during a write cycle are ignored.
// - Write cycle finishes within 5 ms.
// - Serial output is high impedance while deselected.
`timescale 1ns/1ns
`include "eeprom_cfg.svh"

module spi_eeprom #(
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic si,
	input  wire logic pause_n,
	input  wire logic wp_n,
	output      logic so_o,
	output      logic so_oe
);
	import eeprom_pkg::*;

	// Array storage; no contents are preloaded.
	logic [7:0]     mem [0:255];

	// Link domain (sck) state
	link_state_t    st_r;
	logic [2:0]     bitcnt_r;
	logic [7:0]     shin_r;
	logic [7:0]     opc_r;
	logic [7:0]     addr_r;
	logic [7:0]     shout_r;
	logic           out_en_r;
	logic [7:0]     page_r [0:15];
	logic [15:0]    pvalid_r;
	logic [7:0]     stdata_r;
	logic           opc_done_r;
	logic           byte_done_r;
	logic           byte_seen_r;
	logic           gsck;
	link_state_t    fr_st_r;
	logic           fr_opc_done_r;
	logic           fr_whole_r;
	logic           fr_seen_r;
	logic [15:0]    fr_pvalid_r;

	// Reference domain state and its two-flop copies clocked on sck
	logic           cs_s;
	logic           cs_d_r;
	logic           wp_s;
	logic           wel_r;
	logic [1:0]     bp_r;
	logic           start;
	logic           busy;
	logic           done;
	logic [7:0]     wbase_r;
	logic [7:0]     wpage_r [0:15];
	logic [15:0]    wvalid_r;
	logic           wkind_r;
	logic [7:0]     wstat_r;
	logic           busy_sck_r1;
	logic           busy_sck_r2;
	logic           wel_sck_r1;
	logic           wel_sck_r2;
	logic [1:0]     bp_sck_r1;
	logic [1:0]     bp_sck_r2;

	function automatic logic [2:0] op_kind(input logic [7:0] op);
		// Bit 3 is don't-care; upper nibble must be zero.
		if (op[7:4] != 4'h0)
			return 3'h0;
		return op[2:0];
	endfunction

	function automatic logic protected_addr(input logic [1:0] bp, input logic [7:0] a);
		case (bp)
			2'h0:    return 1'b0;
			2'h1:    return a[7:6] == 2'h3;
			2'h2:    return a[7];
			default: return 1'b1;
		endcase
	endfunction

	// Gated clock freezes the engine during pause; pause changes only while sck low.
	assign gsck = sck & pause_n;

	// Status levels into the link domain; they change slowly relative to sck.
	always_ff @(posedge sck) begin
		busy_sck_r1 <= busy;
		busy_sck_r2 <= busy_sck_r1;
		wel_sck_r1  <= wel_r;
		wel_sck_r2  <= wel_sck_r1;
		bp_sck_r1   <= bp_r;
		bp_sck_r2   <= bp_sck_r1;
	end

	wire [7:0] shin_nxt = {shin_r[6:0], si};

	// Link engine; chip select high resets it asynchronously to the frame.
	always_ff @(posedge gsck or posedge cs_n) begin
		if (cs_n) begin
			st_r        <= ST_OPCODE;
			bitcnt_r    <= 3'h0;
			opc_done_r  <= 1'b0;
			byte_done_r <= 1'b0;
			byte_seen_r <= 1'b0;
			pvalid_r    <= 16'h0000;
		end else begin
			shin_r   <= shin_nxt;
			bitcnt_r <= bitcnt_r + 3'h1;
			byte_done_r <= (bitcnt_r == 3'h7);
			if (bitcnt_r == 3'h7) begin
				case (st_r)
					ST_OPCODE: begin
						opc_r      <= shin_nxt;
						opc_done_r <= 1'b1;
						case (op_kind(shin_nxt))
							`OPC_ARRAY_READ, `OPC_ARRAY_WRITE: st_r <= ST_ADDR;
							`OPC_STATUS_READ:  st_r <= ST_STATUS;
							`OPC_STATUS_WRITE: st_r <= ST_DATA;
							`OPC_LATCH_SET, `OPC_LATCH_CLEAR: st_r <= ST_IGNORE;
							default: st_r <= ST_IGNORE;
						endcase
					end
					ST_ADDR: begin
						addr_r <= shin_nxt;
						st_r   <= ST_DATA;
					end
					ST_DATA: begin
						byte_seen_r <= 1'b1;
						if (op_kind(opc_r) == `OPC_ARRAY_WRITE) begin
							page_r[addr_r[3:0]]   <= shin_nxt;
							pvalid_r[addr_r[3:0]] <= 1'b1;
							addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
						end else if (op_kind(opc_r) == `OPC_STATUS_WRITE) begin
							stdata_r <= shin_nxt;
						end else begin
							addr_r <= addr_r + 8'h01;
						end
					end
					default: st_r <= st_r;
				endcase
			end
		end
	end

	// Frame summary taken as select rises; the engine's own copies are cleared by that edge
	always_ff @(posedge cs_n) begin
		fr_st_r       <= st_r;
		fr_opc_done_r <= opc_done_r;
		fr_whole_r    <= byte_done_r;
		fr_seen_r     <= byte_seen_r;
		fr_pvalid_r   <= pvalid_r;
	end

	wire is_read = (op_kind(opc_r) == `OPC_ARRAY_READ);

	// Output shifts on the falling edge so the host samples on the rising edge.
	always_ff @(negedge gsck or posedge cs_n) begin
		if (cs_n) begin
			out_en_r <= 1'b0;
			shout_r  <= 8'h00;
		end else if (bitcnt_r == 3'h0 && st_r == ST_DATA && is_read) begin
			out_en_r <= !busy_sck_r2;
			shout_r  <= mem[addr_r];
		end else if (bitcnt_r == 3'h0 && st_r == ST_STATUS) begin
			out_en_r <= 1'b1;
			shout_r  <= {4'h0, bp_sck_r2, wel_sck_r2, busy_sck_r2};
		end else begin
			shout_r <= {shout_r[6:0], 1'b0};
		end
	end

	assign so_o  = shout_r[7];
	assign so_oe = out_en_r & pause_n;

	// Reference side: watch select for its rising edge.
	pin_sync #(.W(2)) u_sync (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.async_in  ({cs_n, wp_n}),
		.reset_val (2'h3),
		.sync_out  ({cs_s, wp_s})
	);

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			cs_d_r <= 1'b1;
		else
			cs_d_r <= cs_s;
	end

	// Link registers are stable while select is high, so they are read after the rise.
	wire cs_rise  = cs_s & ~cs_d_r;
	wire [2:0] k  = op_kind(opc_r);
	wire whole    = fr_whole_r;
	wire do_set   = cs_rise && fr_opc_done_r && whole && k == `OPC_LATCH_SET && fr_st_r == ST_IGNORE;
	wire do_clr   = cs_rise && fr_opc_done_r && whole && k == `OPC_LATCH_CLEAR && fr_st_r == ST_IGNORE;
	wire wr_ok    = cs_rise && whole && fr_seen_r && wel_r && wp_s && !busy;
	wire do_awr   = wr_ok && k == `OPC_ARRAY_WRITE;
	wire do_swr   = wr_ok && k == `OPC_STATUS_WRITE;
	assign start  = do_awr || do_swr;

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			wel_r <= 1'b0;
		else if (!wp_s)
			wel_r <= 1'b0;
		else if (do_set)
			wel_r <= 1'b1;
		else if (done || do_clr || do_awr || do_swr)
			wel_r <= 1'b0;
	end

	// Capture the page at write start; link may reuse its buffer afterwards.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wvalid_r <= 16'h0000;
			wkind_r  <= 1'b0;
		end else if (start) begin
			wbase_r  <= addr_r;
			wvalid_r <= fr_pvalid_r;
			wkind_r  <= do_swr;
			wstat_r  <= stdata_r;
			for (int i = 0; i < 16; i++)
				wpage_r[i] <= page_r[i];
		end
	end

	write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.start   (start),
		.busy    (busy),
		.done    (done)
	);

	// Commit at cycle end; protected locations are left untouched.
	always_ff @(posedge ref_clk) begin
		if (done && !wkind_r) begin
			for (int i = 0; i < 16; i++)
				if (wvalid_r[i] && !protected_addr(bp_r, {wbase_r[7:4], 4'(i)}))
					mem[{wbase_r[7:4], 4'(i)}] <= wpage_r[i];
		end
	end

	// Block protect is nonvolatile; reset value models the shipped setting.
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			bp_r <= `BP_RESET;
		else if (done && wkind_r)
			bp_r <= wstat_r[`STAT_BP_HI_BIT:`STAT_BP_LO_BIT];
	end
endmodule

// ---- spi_eeprom_properties.sv ----
// Port-level checks for the serial EEPROM command logic.
// Sees only the top ports; sampled on ref_clk, link lines treated as levels.
`timescale 1ns/1ns

module spi_eeprom_properties #(
	parameter int WRITE_CYCLES = 125000
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic pause_n,
	input wire logic wp_n,
	input wire logic so_o,
	input wire logic so_oe
);
	logic sck_r;
	logic sck_hi;

	// Two samples high means no falling edge in between
	always_ff @(posedge ref_clk) begin
		sck_r <= sck;
	end
	assign sck_hi = sck && sck_r;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_select;
		$fell(cs_n);
	endsequence
	sequence s_deselect;
		$rose(cs_n);
	endsequence

	a_oe_deselect: assert property (cs_n |-> !so_oe)
		else $error("serial output driven while deselected");
	a_end_read: assert property (s_deselect |-> !so_oe ##1 !so_oe)
		else $error("output still driven after deselect");
	a_oe_paused: assert property (!pause_n |-> !so_oe)
		else $error("output driven while paused");
	a_so_paused: assert property (!pause_n && !$past(pause_n) && !cs_n |-> $stable(so_o))
		else $error("serial output moved while paused");
	a_so_at_fall: assert property (sck_hi |-> $stable(so_o))
		else $error("serial output moved while clock high");
	a_oe_at_fall: assert property (sck_hi && $stable(cs_n) && $stable(pause_n) |-> $stable(so_oe))
		else $error("output enable moved while clock high");
	a_oe_rise_ok: assert property ($rose(so_oe) |-> !sck && !cs_n && pause_n)
		else $error("output enable rose outside a clock low phase");
	a_no_early_out: assert property (s_select |-> !so_oe [*8])
		else $error("output driven before opcode complete");
endmodule

bind spi_eeprom spi_eeprom_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n), .wp_n(wp_n),
	.so_o(so_o), .so_oe(so_oe));

// ---- spi_host_model.sv ----
// Host side of the serial link: frames, mode 0 bytes, optional pause.
// Clock stands low between frames; 125 ns period, free of ref_clk phase.
`timescale 1ns/1ns

module spi_host_model (
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	output logic      pause_n,
	input  wire logic so_o
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		pause_n = 1'b1;
	end

	task open;
		#50 cs_n = 1'b0;
		#63;
	endtask

	// Hold gap lets the reference domain see the deselect
	task close;
		#40 cs_n = 1'b1;
		si = ~si;
		#300;
	endtask

	task xbyte(input logic [7:0] tx, input int nb, input bit hold, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			if (hold && i == 4) begin
				pause_n = 1'b0;
				repeat (2) begin
					si = ~si;
					#62 sck = 1'b1;
					#63 sck = 1'b0;
				end
				pause_n = 1'b1;
				#20;
			end
			si = tx[i];
			#63 sck = 1'b1;
			rx[i] = so_o;
			#62 sck = 1'b0;
		end
	endtask
endmodule

// ---- spi_eeprom_tb.sv ----
// Self-checking bench for the serial EEPROM command logic.
// Host model drives the link; write cycle shortened to 200 ref_clk cycles.
`timescale 1ns/1ns

module spi_eeprom_tb;
	import eeprom_pkg::*;
	logic       ref_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       wp_n    = 1'b1;
	logic       sck, cs_n, si, pause_n, so_o, so_oe;
	logic [7:0] rx;
	int         mismatches = 0;
	int         total_checks = 0;

	always #20 ref_clk = ~ref_clk;

	spi_eeprom #(.WRITE_CYCLES(200)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .sck(sck),
		.cs_n(cs_n), .si(si), .pause_n(pause_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));
	spi_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n), .so_o(so_o));

	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task stop_test;
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task cmd(input logic [7:0] op);
		host_u.open();
		host_u.xbyte(op, 8, 0, rx);
		host_u.close();
	endtask

	task stat(input logic [7:0] exp, input bit hold);
		host_u.open();
		host_u.xbyte(8'h05, 8, 0, rx);
		host_u.xbyte(8'h00, 8, hold, rx);
		host_u.close();
		chk("status", rx, exp);
	endtask

	// Polls busy with a bounded count; rx keeps the last status
	task wait_idle;
		int n;
		n = 0;
		rx = 8'h01;
		while (rx[0] !== 1'b0 && n < 40) begin
			host_u.open();
			host_u.xbyte(8'h05, 8, 0, rx);
			host_u.xbyte(8'h00, 8, 0, rx);
			host_u.close();
			n++;
		end
		if (rx[0] !== 1'b0) begin
			mismatches++;
			stop_test();
		end
	endtask

	initial begin
		#2_000_000;
		mismatches++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		#2 sys_rst = 1'b0;
		repeat (6) @(posedge ref_clk);
		stat(8'h04, 0);
		cmd(8'h0E);
		stat(8'h06, 1);
		cmd(8'h0C);
		stat(8'h04, 0);
		cmd(8'h06);
		@(posedge ref_clk) #2 wp_n = 1'b0;
		stat(8'h04, 0);
		@(posedge ref_clk) #2 wp_n = 1'b1;
		cmd(8'h06);
		host_u.open();
		host_u.xbyte(8'h02, 8, 0, rx);
		host_u.xbyte(8'h10, 8, 0, rx);
		host_u.xbyte(8'h55, 4, 0, rx);
		host_u.close();
		stat(8'h06, 0);
		host_u.open();
		host_u.xbyte(8'h0A, 8, 0, rx);
		host_u.xbyte(8'h1F, 8, 0, rx);
		host_u.xbyte(8'hA1, 8, 0, rx);
		host_u.xbyte(8'hB2, 8, 0, rx);
		host_u.xbyte(8'hC3, 8, 0, rx);
		host_u.close();
		stat(8'h05, 0);
		host_u.open();
		host_u.xbyte(8'h03, 8, 0, rx);
		host_u.xbyte(8'h10, 8, 0, rx);
		host_u.xbyte(8'h00, 8, 0, rx);
		chk("read_oe_busy", {7'h00, so_oe}, 8'h00);
		host_u.close();
		wait_idle();
		chk("status_done", rx, 8'h04);
		host_u.open();
		host_u.xbyte(8'h0B, 8, 0, rx);
		host_u.xbyte(8'h10, 8, 0, rx);
		host_u.xbyte(8'h00, 8, 1, rx);
		chk("read_wrap", rx, 8'hB2);
		host_u.xbyte(8'h00, 8, 0, rx);
		chk("read_next", rx, 8'hC3);
		host_u.close();
		host_u.open();
		host_u.xbyte(8'hFF, 8, 0, rx);
		host_u.xbyte(8'h00, 8, 0, rx);
		chk("unknown_oe", {7'h00, so_oe}, 8'h00);
		host_u.close();
		cmd(8'h06);
		host_u.open();
		host_u.xbyte(8'h01, 8, 0, rx);
		host_u.xbyte(8'h00, 8, 0, rx);
		host_u.close();
		wait_idle();
		chk("status_write", rx, 8'h00);
		stop_test();
	end
endmodule
